//--- tb/csc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module csc_host_model
  import csc_pkg::*;
(
  input wire logic clk_i, // core clock
  output csc_cmd_s cmd_o, // command word to the block
  output logic wr_o, // write strobe
  output logic rd_o, // read strobe
  input wire logic [15:0] rd_data_i, // read word
  input wire logic rd_valid_i, // read answer
  input wire logic ack_i, // write taken
  input wire logic nack_i // request refused
);
  // quiet bus at time zero
  initial begin
    cmd_o = '0;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  // one strobed request; answer sampled in the cycle after the taking edge
  // gain values handed in are kept in span by the caller
  // single controller here, so no stacked copy needs matching
  task automatic req(input logic w, input logic [7:0] code, input logic [7:0] page,
      input logic [15:0] data, output logic [15:0] rdat, output logic [2:0] resp);
    @(posedge clk_i);
    cmd_o <= '{code: code, page: page, data: data};
    wr_o <= w;
    rd_o <= ~w;
    @(posedge clk_i);
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    // flipped pattern so a stale word never looks like the last command
    cmd_o <= ~cmd_o;
    #1;
    rdat = rd_data_i;
    resp = {rd_valid_i, ack_i, nack_i};
  endtask
endmodule
`default_nettype wire

//--- tb/tb_csc_cal_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_csc_cal_regs;
  import csc_pkg::*;
  logic clk = 1'b0; // core clock
  logic rst_b, ch2_master, clear_faults, nv_load, wr, rd, rd_valid, ack, nack, invalid_command_fault, alert;
  csc_cmd_s cmd; // host command
  csc_cal_s nv1, nv2, ch1_cal, ch2_cal; // restore and in-use values
  csc_cal_s c [2]; // expected copy per channel
  logic [15:0] rd_data; // read word
  logic [1:0][15:0] raw, ocf, ocw, corr, fcorr, wcorr; // current paths
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [31:0] seed = 32'h00000035; // xorshift state
  // 125 MHz clock
  always #4 clk = ~clk;
  csc_host_model host (.clk_i(clk), .cmd_o(cmd), .wr_o(wr), .rd_o(rd), .rd_data_i(rd_data),
    .rd_valid_i(rd_valid), .ack_i(ack), .nack_i(nack));
  csc_cal_regs #(.IW(16)) DUT (.CORE_CLK_I(clk), .RST_B_I(rst_b), .CMD_I(cmd),
    .WR_STB_I(wr), .RD_STB_I(rd), .CH2_MASTER_I(ch2_master), .CLEAR_FAULTS_I(clear_faults),
    .NV_LOAD_I(nv_load), .NV_CH1_I(nv1), .NV_CH2_I(nv2), .IOUT_RAW_I(raw), .OC_FAULT_I(ocf),
    .OC_WARN_I(ocw), .RD_DATA_O(rd_data), .RD_VALID_O(rd_valid), .ACK_O(ack), .NACK_O(nack),
    .IVC_FAULT_O(invalid_command_fault), .SMB_ALERT_O(alert), .CH1_CAL_O(ch1_cal), .CH2_CAL_O(ch2_cal),
    .IOUT_CORR_O(corr), .OC_FAULT_CORR_O(fcorr), .OC_WARN_CORR_O(wcorr));
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // page byte with random filler between the two select bits
  function automatic logic [7:0] pg(logic [1:0] p);
    logic [31:0] r;
    r = rnd();
    return {p[1], r[5:0], p[0]};
  endfunction
  // words as the host should read them back
  function automatic logic [15:0] gword(logic [8:0] g);
    return {5'h10, 2'b00, g};
  endfunction
  function automatic logic [15:0] oword(logic [6:0] o);
    return {5'h1c, {4{o[6]}}, o};
  endfunction
  function automatic logic [15:0] fix(logic [15:0] v, logic [6:0] o);
    return v + {{9{o[6]}}, o};
  endfunction
  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // hang guard, well above the length of the sequence
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      conclude();
    end
  end
  initial begin
    logic [15:0] d, q;
    logic [2:0] rs;
    logic [31:0] r;
    logic [1:0] p;
    logic gsel;
    {rst_b, ch2_master, clear_faults, nv_load} = 4'h4;
    {nv1, nv2, raw, ocf, ocw} = '0;
    c[0] = CSC_CAL_RST;
    c[1] = CSC_CAL_RST;
    repeat (20) @(posedge clk);
    #1;
    check("ch1 rst", ch1_cal, CSC_CAL_RST);
    check("ch2 rst", ch2_cal, CSC_CAL_RST);
    @(posedge clk) rst_b <= 1'b1;
    // reset words of both channels
    for (int k = 0; k < 2; k++) begin
      host.req(1'b0, CSC_CMD_GAIN, pg(k[1:0]), 16'h5a5a, q, rs);
      check("gain rst word", {rs, q}, {3'b100, 16'h8020});
      host.req(1'b0, CSC_CMD_OFFSET, pg(k[1:0]), 16'ha5a5, q, rs);
      check("off rst word", {rs, q}, {3'b100, 16'he000});
    end
    // random writes over the three legal page patterns, with the aliasing corner first
    for (int i = 0; i < 40; i++) begin
      r = rnd();
      p = (r[1:0] == 2'h2) ? 2'h3 : r[1:0];
      gsel = r[2] && i > 0;
      d = (i == 0) ? 16'he401 : r[31:16];
      if (gsel) d[8:0] = CSC_GAIN_MIN + 9'(r[24:8] % 493);
      host.req(1'b1, gsel ? CSC_CMD_GAIN : CSC_CMD_OFFSET, pg(p), d, q, rs);
      check("write resp", rs, 3'b010);
      for (int k = 0; k < 2; k++) begin
        if (p == 2'h3 || p[0] == k[0]) begin
          if (gsel) c[k].gain = d[8:0];
          else c[k].off = {d[10], d[5:0]};
        end
      end
      host.req(1'b0, gsel ? CSC_CMD_GAIN : CSC_CMD_OFFSET, pg(p), ~d, q, rs);
      // page 11 reads answer from channel one
      if (i == 0) check("alias word", q, 16'he7c1);
      if (gsel) check("gain word", {rs, q}, {3'b100, gword(c[p == 2'h1].gain)});
      else check("off word", {rs, q}, {3'b100, oword(c[p == 2'h1].off)});
      check("ch1 cal", ch1_cal, c[0]);
      check("ch2 cal", ch2_cal, c[1]);
    end
    // offset applied to current, fault and warning paths of both channels
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      for (int k = 0; k < 2; k++) begin
        r = rnd();
        raw[k] <= r[15:0];
        ocf[k] <= r[31:16];
        ocw[k] <= r[23:8];
      end
      repeat (3) @(posedge clk);
      #1;
      for (int k = 0; k < 2; k++) begin
        check("iout corr", corr[k], fix(raw[k], c[k].off));
        check("fault corr", fcorr[k], fix(ocf[k], c[k].off));
        check("warn corr", wcorr[k], fix(ocw[k], c[k].off));
      end
    end
    // channel two as slave: refused write, fault, mirror of channel one
    @(posedge clk) ch2_master <= 1'b0;
    for (int k = 1; k < 4; k++) begin
      // the illegal page is refused beside a clear, and the set must win
      if (k == 2) @(posedge clk) clear_faults <= 1'b1;
      host.req(1'b1, CSC_CMD_GAIN, pg(k[1:0]), 16'h0100, q, rs);
      check("slave wr resp", rs, 3'b001);
      check("fault alert", {invalid_command_fault, alert}, 2'b11);
      @(posedge clk) clear_faults <= 1'b1;
      @(posedge clk) clear_faults <= 1'b0;
      #1;
      check("fault clear", {invalid_command_fault, alert}, 2'b00);
    end
    host.req(1'b1, CSC_CMD_GAIN, pg(2'h0), 16'h0040, q, rs);
    check("ch1 wr slave", rs, 3'b010);
    c[0].gain = 9'h040;
    host.req(1'b0, CSC_CMD_GAIN, pg(2'h1), 16'h0000, q, rs);
    check("slave read", {rs, q}, {3'b100, gword(9'h040)});
    check("slave mirror", ch2_cal, c[0]);
    check("slave iout", corr[1], fix(raw[1], c[0].off));
    host.req(1'b0, CSC_CMD_OFFSET, pg(2'h2), 16'h0000, q, rs);
    check("bad page read", {rs, invalid_command_fault}, 4'h2);
    // restore from nonvolatile store
    @(posedge clk) begin
      ch2_master <= 1'b1;
      nv_load <= 1'b1;
      r = rnd();
      nv1 <= r[15:0];
      nv2 <= r[31:16];
    end
    @(posedge clk) nv_load <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("nv ch1", ch1_cal, nv1);
    check("nv ch2", ch2_cal, nv2);
    host.req(1'b0, CSC_CMD_OFFSET, pg(2'h1), 16'h0000, q, rs);
    check("nv off word", {rs, q}, {3'b100, oword(nv2.off)});
    host.req(1'b0, CSC_CMD_GAIN, pg(2'h0), 16'h0000, q, rs);
    check("nv gain word", {rs, q}, {3'b100, gword(nv1.gain)});
    conclude();
  end
endmodule
`default_nettype wire

//--- verilog/csc_cal_field.sv
`timescale 1ns/1ps
`default_nettype none
module csc_cal_field
  import csc_pkg::*;
(
  input wire logic [15:0] wr_data_i, // word written by the host
  input wire csc_cal_s cal_i, // stored state to read back
  output logic [8:0] gain_mant_o, // writable gain bits of wr_data_i
  output logic [6:0] off_mant_o, // writable offset bits of wr_data_i
  output logic [15:0] gain_word_o, // gain word as the host sees it
  output logic [15:0] off_word_o // offset word as the host sees it
);
  // only the writable mantissa bits are kept, the rest is dropped
  assign gain_mant_o = wr_data_i[CSC_GAIN_MW-1:0];
  // sign plus six low bits; bits 9:6 are not stored, so big values alias
  assign off_mant_o = {wr_data_i[CSC_OFF_SIGN_BIT],
                       wr_data_i[CSC_OFF_LOW_MSB:0]};

  // readback: exponent is a constant, never a stored bit
  assign gain_word_o = {CSC_GAIN_EXP, 2'h0, cal_i.gain};
  // five top mantissa bits all mirror the sign
  assign off_word_o = {CSC_OFF_EXP, {4{cal_i.off[CSC_OFF_MW-1]}},
                       cal_i.off};
endmodule
`default_nettype wire

//--- verilog/csc_cal_regs.sv
`timescale 1ns/1ps
`default_nettype none
module csc_cal_regs
  import csc_pkg::*;
#(
  parameter int IW = 16 // current word width
) (
  input wire logic CORE_CLK_I, // core clock, 125 MHz
  input wire logic RST_B_I, // async reset, active low
  input wire csc_cmd_s CMD_I, // code, page and write data
  input wire logic WR_STB_I, // write request, one cycle
  input wire logic RD_STB_I, // read request, one cycle
  input wire logic CH2_MASTER_I, // channel two runs as master
  input wire logic CLEAR_FAULTS_I, // clears the fault flag
  input wire logic NV_LOAD_I, // restore from nonvolatile store
  input wire csc_cal_s NV_CH1_I, // stored channel one values
  input wire csc_cal_s NV_CH2_I, // stored channel two values
  input wire logic [1:0][IW-1:0] IOUT_RAW_I, // raw current per channel
  input wire logic [1:0][IW-1:0] OC_FAULT_I, // raw fault threshold
  input wire logic [1:0][IW-1:0] OC_WARN_I, // raw warning threshold
  output logic [15:0] RD_DATA_O, // read word
  output logic RD_VALID_O, // read answer, one cycle
  output logic ACK_O, // write taken, one cycle
  output logic NACK_O, // request refused, one cycle
  output logic IVC_FAULT_O, // invalid-command fault, sticky
  output logic SMB_ALERT_O, // alert request, active high
  output csc_cal_s CH1_CAL_O, // channel one values in use
  output csc_cal_s CH2_CAL_O, // channel two values in use
  output logic [1:0][IW-1:0] IOUT_CORR_O, // corrected current
  output logic [1:0][IW-1:0] OC_FAULT_CORR_O, // corrected fault threshold
  output logic [1:0][IW-1:0] OC_WARN_CORR_O // corrected warning threshold
);

  // command decode
  logic is_gain; // request names the gain word
  logic is_off; // request names the offset word
  logic is_cal; // request is for this block
  logic [1:0] page_sel; // page bits 7 and 0
  csc_tgt_e tgt; // decoded target

  assign is_gain = (CMD_I.code == CSC_CMD_GAIN);
  assign is_off = (CMD_I.code == CSC_CMD_OFFSET);
  assign is_cal = is_gain || is_off;
  assign page_sel = {CMD_I.page[CSC_PAGE_HI_BIT], CMD_I.page[CSC_PAGE_LO_BIT]};

  // page pattern to channel copy; 10 is not a legal pattern
  always_comb begin
    case (page_sel)
      CSC_PG_CH1: tgt = CSC_TGT_CH1;
      CSC_PG_CH2: tgt = CSC_TGT_CH2;
      CSC_PG_BOTH: tgt = CSC_TGT_BOTH;
      default: tgt = CSC_TGT_BAD;
    endcase
  end

  // write acceptance
  logic wr_req; // write to one of our words
  logic hits_ch2; // target includes channel two
  logic hits_ch1; // target includes channel one
  logic slave_hit; // write reaches a slave channel
  logic wr_ok_ch1; // write lands in channel one
  logic wr_ok_ch2; // write lands in channel two
  logic wr_bad; // write refused
  logic rd_req; // read of one of our words
  logic rd_bad; // read on illegal page

  assign wr_req = WR_STB_I && is_cal;
  assign rd_req = RD_STB_I && is_cal;
  assign hits_ch1 = (tgt == CSC_TGT_CH1) || (tgt == CSC_TGT_BOTH);
  assign hits_ch2 = (tgt == CSC_TGT_CH2) || (tgt == CSC_TGT_BOTH);
  // a both-channel write while slave is refused whole, so the pair
  // never ends up half written
  assign slave_hit = wr_req && hits_ch2 && !CH2_MASTER_I;
  assign wr_ok_ch1 = wr_req && hits_ch1 && !slave_hit;
  assign wr_ok_ch2 = wr_req && hits_ch2 && !slave_hit;
  assign wr_bad = slave_hit || (wr_req && (tgt == CSC_TGT_BAD));
  assign rd_bad = rd_req && (tgt == CSC_TGT_BAD);

  // stored state per channel
  csc_cal_s ch1_reg; // channel one copy
  csc_cal_s ch2_reg; // channel two copy
  csc_cal_s ch2_eff; // channel two as used
  csc_cal_s rd_cal; // copy selected for readback
  logic [8:0] wr_gain; // writable gain bits
  logic [6:0] wr_off; // writable offset bits
  logic [15:0] gain_word; // gain readback word
  logic [15:0] off_word; // offset readback word

  // a slave channel two follows channel one, its own copy is kept
  assign ch2_eff = CH2_MASTER_I ? ch2_reg : ch1_reg;
  // page 11 reads return channel one
  assign rd_cal = (tgt == CSC_TGT_CH2) ? ch2_eff : ch1_reg;

  // field shaping and readback words
  csc_cal_field u_field (
    .wr_data_i(CMD_I.data),
    .cal_i(rd_cal),
    .gain_mant_o(wr_gain),
    .off_mant_o(wr_off),
    .gain_word_o(gain_word),
    .off_word_o(off_word)
  );

  // channel one copy: reset defaults, nonvolatile restore, host write
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ch1_reg <= CSC_CAL_RST;
    end else if (NV_LOAD_I) begin
      ch1_reg <= NV_CH1_I;
    end else if (wr_ok_ch1) begin
      // only the named word changes; exponents are never stored
      if (is_gain) begin
        ch1_reg.gain <= wr_gain;
      end else begin
        ch1_reg.off <= wr_off;
      end
    end
  end

  // channel two copy, same shape as channel one
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ch2_reg <= CSC_CAL_RST;
    end else if (NV_LOAD_I) begin
      ch2_reg <= NV_CH2_I;
    end else if (wr_ok_ch2) begin
      if (is_gain) begin
        ch2_reg.gain <= wr_gain;
      end else begin
        ch2_reg.off <= wr_off;
      end
    end
  end

  // values handed to the rest of the controller, registered
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      CH1_CAL_O <= CSC_CAL_RST;
      CH2_CAL_O <= CSC_CAL_RST;
    end else begin
      CH1_CAL_O <= ch1_reg;
      CH2_CAL_O <= ch2_eff;
    end
  end

  // read path: answer one cycle after the strobe
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      RD_DATA_O <= '0;
      RD_VALID_O <= 1'b0;
    end else begin
      RD_VALID_O <= rd_req && !rd_bad;
      if (rd_req && !rd_bad) begin
        RD_DATA_O <= is_gain ? gain_word : off_word;
      end
    end
  end

  // write answer: ack or nack, one cycle after the strobe
  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      ACK_O <= 1'b0;
      NACK_O <= 1'b0;
    end else begin
      ACK_O <= wr_ok_ch1 || wr_ok_ch2;
      NACK_O <= wr_bad || rd_bad;
    end
  end

  // invalid-command fault: sticky, set wins over a clear in the
  // same cycle so a refused write is never lost
  logic ivc_next; // next fault flag

  assign ivc_next = (IVC_FAULT_O && !CLEAR_FAULTS_I) || wr_bad;

  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      IVC_FAULT_O <= 1'b0;
      SMB_ALERT_O <= 1'b0;
    end else begin
      IVC_FAULT_O <= ivc_next;
      SMB_ALERT_O <= ivc_next;
    end
  end

  // offset correction per channel, using the values in use
  logic [1:0][6:0] off_use; // offset in use per channel

  assign off_use[0] = ch1_reg.off;
  assign off_use[1] = ch2_eff.off;

  for (genvar c = 0; c < 2; c++) begin : g_ch
    csc_offset_apply #(.IW(IW)) u_apply (
      .clk_i(CORE_CLK_I),
      .rst_b_i(RST_B_I),
      .off_i(off_use[c]),
      .raw_i(IOUT_RAW_I[c]),
      .fault_i(OC_FAULT_I[c]),
      .warn_i(OC_WARN_I[c]),
      .raw_o(IOUT_CORR_O[c]),
      .fault_o(OC_FAULT_CORR_O[c]),
      .warn_o(OC_WARN_CORR_O[c])
    );
  end

  // helper: low during reset and in the first cycle after reset release only
  logic rst_seen_reg; // set once a clock edge has passed

  always_ff @(posedge CORE_CLK_I or negedge RST_B_I) begin
    if (!RST_B_I) begin
      rst_seen_reg <= 1'b0;
    end else begin
      rst_seen_reg <= 1'b1;
    end
  end

  // checks
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (!RST_B_I);

  sequence s_wr_slave;
    WR_STB_I && is_cal && hits_ch2 && !CH2_MASTER_I;
  endsequence

  sequence s_wr_gain_ch1;
    WR_STB_I && is_gain && (tgt == CSC_TGT_CH1) && !NV_LOAD_I;
  endsequence

  sequence s_rd_off;
    RD_STB_I && is_off && (tgt != CSC_TGT_BAD);
  endsequence

  a_slave_nack: assert property (s_wr_slave |=> NACK_O && !ACK_O && SMB_ALERT_O)
    else $error("slave channel write not refused");

  a_slave_keep: assert property ((s_wr_slave and !NV_LOAD_I) |=> $stable(ch2_reg))
    else $error("slave channel copy changed by a write");

  a_ch1_accept: assert property (
    WR_STB_I && is_cal && (tgt == CSC_TGT_CH1) |=> ACK_O && !NACK_O)
    else $error("channel one write not taken");

  a_gain_exp: assert property (
    RD_STB_I && is_gain && (tgt != CSC_TGT_BAD)
    |=> RD_VALID_O && (RD_DATA_O[15:CSC_EXP_LSB] == CSC_GAIN_EXP))
    else $error("gain exponent not fixed");

  a_off_sext: assert property (s_rd_off |=> RD_VALID_O
    && (RD_DATA_O[15:CSC_EXP_LSB] == CSC_OFF_EXP)
    && ((RD_DATA_O[10:6] == 5'h00) || (RD_DATA_O[10:6] == 5'h1f)))
    else $error("offset word not sign extended");

  a_reset_vals: assert property (!rst_seen_reg
    |-> (ch1_reg == CSC_CAL_RST) && (ch2_reg == CSC_CAL_RST))
    else $error("calibration reset values wrong");

  a_slave_mirror: assert property (!CH2_MASTER_I |=> CH2_CAL_O == $past(ch1_reg))
    else $error("slave channel not following channel one");

  a_ro_discard: assert property (s_wr_gain_ch1
    |=> ch1_reg.gain == $past(CMD_I.data[8:0]))
    else $error("gain write not stored in writable bits");

  // one cycle only: a clear may legally arrive in the very next cycle
  a_alert_hold: assert property (SMB_ALERT_O && !CLEAR_FAULTS_I |=> SMB_ALERT_O)
    else $error("alert dropped without a clear");

  // refused pages, stored offset bits, restore and fault clearing
  sequence s_wr_bad_page;
    WR_STB_I && is_cal && (tgt == CSC_TGT_BAD);
  endsequence

  sequence s_rd_bad_page;
    RD_STB_I && is_cal && (tgt == CSC_TGT_BAD);
  endsequence

  // offset write to channel one that no restore overrides
  sequence s_wr_off_ch1;
    WR_STB_I && is_off && (tgt == CSC_TGT_CH1) && !NV_LOAD_I;
  endsequence

  // a clear with no write strobe beside it, so nothing can set the flag
  sequence s_quiet_clear;
    CLEAR_FAULTS_I && !WR_STB_I;
  endsequence

  a_bad_wr: assert property (s_wr_bad_page
    |=> NACK_O && !ACK_O && IVC_FAULT_O)
    else $error("write on illegal page not refused");

  a_bad_rd: assert property (s_rd_bad_page
    |=> NACK_O && !RD_VALID_O && !ACK_O)
    else $error("read on illegal page not refused");

  a_master_wr: assert property (
    WR_STB_I && is_cal && (tgt == CSC_TGT_CH2) && CH2_MASTER_I |=> ACK_O && !NACK_O)
    else $error("master channel two write not taken");

  // the sign lands in the top stored bit, word bits 9:6 are dropped
  a_off_store: assert property (s_wr_off_ch1
    |=> ch1_reg.off == {$past(CMD_I.data[CSC_OFF_SIGN_BIT]),
                        $past(CMD_I.data[CSC_OFF_LOW_MSB:0])})
    else $error("offset write stored the wrong bits");

  // page 01 reads answer from the channel two copy while it is master
  a_rd_chan2: assert property (
    RD_STB_I && is_gain && (tgt == CSC_TGT_CH2) && CH2_MASTER_I
    |=> RD_DATA_O[CSC_GAIN_MW-1:0] == $past(ch2_reg.gain))
    else $error("page 01 read not from channel two");

  // page 11 reads answer from channel one
  a_rd_both: assert property (
    RD_STB_I && is_gain && (tgt == CSC_TGT_BOTH)
    |=> RD_DATA_O[CSC_GAIN_MW-1:0] == $past(ch1_reg.gain))
    else $error("page 11 read not from channel one");

  a_slave_rd: assert property (
    RD_STB_I && is_gain && (tgt == CSC_TGT_CH2) && !CH2_MASTER_I
    |=> RD_DATA_O[CSC_GAIN_MW-1:0] == $past(ch1_reg.gain))
    else $error("slave channel two read not from channel one");

  // restore replaces both copies whole, ahead of any host write
  a_nv_restore: assert property (NV_LOAD_I
    |=> (ch1_reg == $past(NV_CH1_I)) && (ch2_reg == $past(NV_CH2_I)))
    else $error("restore values not loaded");

  a_fault_clear: assert property (s_quiet_clear
    |=> !IVC_FAULT_O && !SMB_ALERT_O)
    else $error("fault flag survived a clear");

  // a refused write beside a clear must not be lost
  a_set_wins: assert property (s_wr_bad_page ##0 CLEAR_FAULTS_I
    |=> IVC_FAULT_O && SMB_ALERT_O)
    else $error("refused write lost to a clear");
endmodule
`default_nettype wire

//--- verilog/csc_offset_apply.sv
`timescale 1ns/1ps
`default_nettype none
module csc_offset_apply
  import csc_pkg::*;
#(
  parameter int IW = 16 // current word width
) (
  input wire logic clk_i, // core clock
  input wire logic rst_b_i, // async reset, active low
  input wire logic [6:0] off_i, // signed offset, 62.5 mA counts
  input wire logic [IW-1:0] raw_i, // raw output current
  input wire logic [IW-1:0] fault_i, // raw overcurrent fault threshold
  input wire logic [IW-1:0] warn_i, // raw overcurrent warning threshold
  output logic [IW-1:0] raw_o, // corrected current
  output logic [IW-1:0] fault_o, // corrected fault threshold
  output logic [IW-1:0] warn_o // corrected warning threshold
);
  logic [IW-1:0] off_ext; // offset widened by sign

  assign off_ext = {{(IW-CSC_OFF_MW){off_i[CSC_OFF_MW-1]}}, off_i};

  // one offset corrects all three quantities; sums wrap at IW bits
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      raw_o <= '0;
      fault_o <= '0;
      warn_o <= '0;
    end else begin
      raw_o <= raw_i + off_ext;
      fault_o <= fault_i + off_ext;
      warn_o <= warn_i + off_ext;
    end
  end

  a_offset_sum: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    ##1 (fault_o - warn_o) == ($past(fault_i) - $past(warn_i)))
    else $error("offset not applied equally to thresholds");
endmodule
`default_nettype wire

//--- verilog/csc_pkg.sv
package csc_pkg;
  // command codes of the two calibration words
  localparam logic [7:0] CSC_CMD_GAIN = 8'h38;
  localparam logic [7:0] CSC_CMD_OFFSET = 8'h39;
  // fixed exponents: -16 for gain, -4 for offset
  localparam logic [4:0] CSC_GAIN_EXP = 5'h10;
  localparam logic [4:0] CSC_OFF_EXP = 5'h1c;
  // stored mantissa widths (writable bits only)
  localparam int CSC_GAIN_MW = 9;
  localparam int CSC_OFF_MW = 7;
  // field positions inside the 16-bit word
  localparam int CSC_EXP_LSB = 11;
  localparam int CSC_OFF_SIGN_BIT = 10;
  localparam int CSC_OFF_LOW_MSB = 5;
  // values after reset
  localparam logic [8:0] CSC_GAIN_RST = 9'h020;
  localparam logic [6:0] CSC_OFF_RST = 7'h00;
  // supported gain span, host side keeps to it
  localparam logic [8:0] CSC_GAIN_MIN = 9'h010;
  localparam logic [8:0] CSC_GAIN_MAX = 9'h1fc;
  // page bit positions and patterns
  localparam int CSC_PAGE_HI_BIT = 7;
  localparam int CSC_PAGE_LO_BIT = 0;
  localparam logic [1:0] CSC_PG_CH1 = 2'h0;
  localparam logic [1:0] CSC_PG_CH2 = 2'h1;
  localparam logic [1:0] CSC_PG_BOTH = 2'h3;

  // one channel's calibration state
  typedef struct packed {
    logic [8:0] gain;
    logic [6:0] off;
  } csc_cal_s;

  // one command from the host interface logic
  typedef struct packed {
    logic [7:0] code;
    logic [7:0] page;
    logic [15:0] data;
  } csc_cmd_s;

  localparam csc_cal_s CSC_CAL_RST = '{gain: CSC_GAIN_RST, off: CSC_OFF_RST};

  // page decode result
  typedef enum {CSC_TGT_CH1, CSC_TGT_CH2, CSC_TGT_BOTH, CSC_TGT_BAD} csc_tgt_e;
endpackage
